// [shared/pet_pkg.sv]
package pet_pkg;

    // =========================================================
    // register offsets (word index; byte address is four times)
    localparam logic [9:0] REG_POWER_CONTROL_TWO = 10'h002;
    localparam logic [9:0] REG_CHARGE_PUMP_CONTROL = 10'h04c;
    localparam logic [9:0] REG_OFFSET_SERVO_CONTROL = 10'h054;
    localparam logic [9:0] REG_FIRST_INTERFACE_CLOCKING = 10'h200;
    localparam logic [9:0] REG_SECOND_INTERFACE_CLOCKING = 10'h204;
    localparam logic [9:0] REG_CLOCK_GATING_CONTROL = 10'h208;
    localparam logic [9:0] REG_FIRST_LOOP_CONTROL = 10'h220;
    localparam logic [9:0] REG_SECOND_LOOP_CONTROL = 10'h240;
    localparam logic [9:0] REG_IRQ_STATUS = 10'h300;
    localparam logic [9:0] REG_IRQ_MASK = 10'h301;
    localparam logic [9:0] REG_THERMAL_STATUS = 10'h302;

    // =========================================================
    // field positions
    localparam int BIT_SENSOR_ENABLE = 14;
    localparam int BIT_OUTPUT_DISABLE = 13;
    localparam int BIT_CHARGE_PUMP = 15;
    localparam int BIT_RIGHT_SERVO = 1;
    localparam int BIT_LEFT_SERVO = 0;
    localparam int BIT_INTERFACE_CLOCK = 0;
    localparam int BIT_SLOW_CLOCK = 4;
    localparam int BIT_FIRST_PROC = 3;
    localparam int BIT_SECOND_PROC = 2;
    localparam int BIT_MIXER = 1;
    localparam int BIT_LOOP_ENABLE = 0;
    localparam int BIT_IRQ_WARNING = 0;
    localparam int BIT_IRQ_SHUTDOWN = 1;

    // =========================================================
    // reset values
    localparam logic [15:0] RST_POWER_CONTROL_TWO = 16'h6000;
    localparam logic [15:0] RST_ZERO = 16'h0000;
    localparam logic [1:0] RST_IRQ_MASK = 2'h3;

    // =========================================================
    // thermal levels and filtering
    localparam int SHUTDOWN_CELSIUS = 150;
    localparam int WARNING_CELSIUS = 125;
    localparam int FILTER_TIME_NS = 1000;
    localparam int CLOCK_PERIOD_NS = 100;
    localparam int FILTER_CYCLES = FILTER_TIME_NS / CLOCK_PERIOD_NS;

    // =========================================================
    // carriers
    typedef struct packed {
        logic [9:0] addr;
        logic [15:0] wdata;
        logic write;
        logic read;
    } pet_bus_s;

    typedef struct packed {
        logic charge_pump_enable;
        logic right_servo_enable;
        logic left_servo_enable;
        logic first_interface_clock_enable;
        logic second_interface_clock_enable;
        logic slow_timeout_clock_enable;
        logic first_interface_processing_clock_enable;
        logic second_interface_processing_clock_enable;
        logic mixing_processor_clock_enable;
        logic first_loop_enable;
        logic second_loop_enable;
    } pet_enables_s;

endpackage : pet_pkg

// [rtl/pet_sync.sv]
`timescale 1ns/100ps
`default_nettype none

// =========================================================
// two-stage synchroniser, one per bit
module pet_sync #(
    parameter int WIDTH = 2
) (
    // clock, reset, enable
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic i_enable,
    // data
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] first_stage;
    logic [WIDTH-1:0] next_first_stage;
    logic [WIDTH-1:0] next_sync;

    always_comb
    begin
        next_first_stage = first_stage;
        next_sync = o_sync;
        if (i_enable)
        begin
            next_first_stage = i_async;
            next_sync = first_stage;
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (!i_rstn)
        begin
            first_stage <= '0;
            o_sync <= '0;
        end
        else
        begin
            first_stage <= next_first_stage;
            o_sync <= next_sync;
        end
    end

endmodule : pet_sync

`default_nettype wire

// [rtl/pet_filter.sv]
`timescale 1ns/100ps
`default_nettype none

// =========================================================
// holds a level until it has stood steady for COUNT cycles
module pet_filter #(
    parameter int COUNT = pet_pkg::FILTER_CYCLES
) (
    // clock, reset, enable
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic i_enable,
    // level
    input wire logic i_level,
    output logic o_level
);

    localparam int CW = $clog2(COUNT + 1);
    localparam logic [CW-1:0] LAST = CW'(COUNT - 1);

    logic [CW-1:0] count;
    logic [CW-1:0] next_count;
    logic next_level;

    always_comb
    begin
        next_count = count;
        next_level = o_level;
        if (i_enable)
        begin
            if (i_level == o_level)
            begin
                next_count = '0;
            end
            else if (count == LAST)
            begin
                next_count = '0;
                next_level = i_level;
            end
            else
            begin
                next_count = count + CW'(1);
            end
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (!i_rstn)
        begin
            count <= '0;
            o_level <= 1'b0;
        end
        else
        begin
            count <= next_count;
            o_level <= next_level;
        end
    end

endmodule : pet_filter

`default_nettype wire

// [rtl/pet_power_enable_thermal_guard.sv]
// Our own choice: strobed register access.
`timescale 1ns/100ps
`default_nettype none

module pet_power_enable_thermal_guard #(
    parameter int FILTER_COUNT = pet_pkg::FILTER_CYCLES
) (
    // clock, reset, enable
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic i_enable,
    // register port
    input wire logic [9:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_write,
    input wire logic i_read,
    output logic [15:0] o_rdata,
    // temperature comparator levels from the analog sensor
    input wire logic i_temp_warning,
    input wire logic i_temp_shutdown,
    // zero-cross timeout request from the volume logic
    input wire logic i_zero_cross_request,
    // enables and gates
    output pet_pkg::pet_enables_s o_enables,
    output logic o_zero_cross_timeout_active,
    // speaker drive permits
    output logic o_speaker_left_out_enable,
    output logic o_speaker_right_out_enable,
    // thermal status to general-purpose pins
    output logic o_warning_pin,
    output logic o_shutdown_pin,
    // interrupt
    output logic o_irq
);

    // =========================================================
    // register state
    logic [15:0] power_control_two;
    logic [15:0] next_power_control_two;
    pet_pkg::pet_enables_s enables;
    pet_pkg::pet_enables_s next_enables;
    logic [1:0] irq_status;
    logic [1:0] next_irq_status;
    logic [1:0] irq_mask;
    logic [1:0] next_irq_mask;
    logic [15:0] next_rdata;

    // =========================================================
    // thermal input path
    logic [1:0] temp_sync;
    logic warning_level;
    logic shutdown_level;
    logic warning_seen;
    logic shutdown_seen;
    logic next_warning_seen;
    logic next_shutdown_seen;
    logic sensor_on;
    logic output_disable_on;
    logic warning_rise;
    logic shutdown_rise;

    pet_sync #(
        .WIDTH(2)
    ) u_sync (
        .i_clock(i_clock),
        .i_rstn(i_rstn),
        .i_enable(i_enable),
        .i_async({i_temp_shutdown, i_temp_warning}),
        .o_sync(temp_sync)
    );

    // comparator chatter near the trip point must not toggle the speakers
    pet_filter #(
        .COUNT(FILTER_COUNT)
    ) u_warning_filter (
        .i_clock(i_clock),
        .i_rstn(i_rstn),
        .i_enable(i_enable),
        .i_level(temp_sync[0] & sensor_on),
        .o_level(warning_level)
    );

    pet_filter #(
        .COUNT(FILTER_COUNT)
    ) u_shutdown_filter (
        .i_clock(i_clock),
        .i_rstn(i_rstn),
        .i_enable(i_enable),
        .i_level(temp_sync[1] & sensor_on),
        .o_level(shutdown_level)
    );

    assign sensor_on = power_control_two[pet_pkg::BIT_SENSOR_ENABLE];
    assign output_disable_on = power_control_two[pet_pkg::BIT_OUTPUT_DISABLE];
    assign warning_rise = warning_level & ~warning_seen;
    assign shutdown_rise = shutdown_level & ~shutdown_seen;

    // =========================================================
    // address decode helper
    function automatic logic hit(input logic [9:0] addr, input logic [9:0] reg_addr);
        hit = (addr == reg_addr);
    endfunction : hit

    // =========================================================
    // register writes and event capture
    always_comb
    begin
        next_power_control_two = power_control_two;
        next_enables = enables;
        next_irq_status = irq_status;
        next_irq_mask = irq_mask;
        next_warning_seen = warning_seen;
        next_shutdown_seen = shutdown_seen;
        if (i_enable)
        begin
            next_warning_seen = warning_level;
            next_shutdown_seen = shutdown_level;
            if (i_write)
            begin
                if (hit(i_addr, pet_pkg::REG_POWER_CONTROL_TWO))
                begin
                    next_power_control_two = RST_MASKED(i_wdata);
                end
                else if (hit(i_addr, pet_pkg::REG_CHARGE_PUMP_CONTROL))
                begin
                    next_enables.charge_pump_enable =
                        i_wdata[pet_pkg::BIT_CHARGE_PUMP];
                end
                else if (hit(i_addr, pet_pkg::REG_OFFSET_SERVO_CONTROL))
                begin
                    next_enables.right_servo_enable = i_wdata[pet_pkg::BIT_RIGHT_SERVO];
                    next_enables.left_servo_enable = i_wdata[pet_pkg::BIT_LEFT_SERVO];
                end
                else if (hit(i_addr, pet_pkg::REG_FIRST_INTERFACE_CLOCKING))
                begin
                    next_enables.first_interface_clock_enable =
                        i_wdata[pet_pkg::BIT_INTERFACE_CLOCK];
                end
                else if (hit(i_addr, pet_pkg::REG_SECOND_INTERFACE_CLOCKING))
                begin
                    next_enables.second_interface_clock_enable =
                        i_wdata[pet_pkg::BIT_INTERFACE_CLOCK];
                end
                else if (hit(i_addr, pet_pkg::REG_CLOCK_GATING_CONTROL))
                begin
                    next_enables.slow_timeout_clock_enable =
                        i_wdata[pet_pkg::BIT_SLOW_CLOCK];
                    next_enables.first_interface_processing_clock_enable =
                        i_wdata[pet_pkg::BIT_FIRST_PROC];
                    next_enables.second_interface_processing_clock_enable =
                        i_wdata[pet_pkg::BIT_SECOND_PROC];
                    next_enables.mixing_processor_clock_enable =
                        i_wdata[pet_pkg::BIT_MIXER];
                end
                // loop enables are plain bits; ordering is left to software
                else if (hit(i_addr, pet_pkg::REG_FIRST_LOOP_CONTROL))
                begin
                    next_enables.first_loop_enable = i_wdata[pet_pkg::BIT_LOOP_ENABLE];
                end
                else if (hit(i_addr, pet_pkg::REG_SECOND_LOOP_CONTROL))
                begin
                    next_enables.second_loop_enable = i_wdata[pet_pkg::BIT_LOOP_ENABLE];
                end
                else if (hit(i_addr, pet_pkg::REG_IRQ_STATUS))
                begin
                    next_irq_status = irq_status & ~i_wdata[1:0];
                end
                else if (hit(i_addr, pet_pkg::REG_IRQ_MASK))
                begin
                    next_irq_mask = i_wdata[1:0];
                end
            end
            // set wins over a clear in the same cycle
            if (warning_rise)
            begin
                next_irq_status[pet_pkg::BIT_IRQ_WARNING] = 1'b1;
            end
            if (shutdown_rise)
            begin
                next_irq_status[pet_pkg::BIT_IRQ_SHUTDOWN] = 1'b1;
            end
        end
    end

    // only the two thermal bits are implemented in power register two
    function automatic logic [15:0] RST_MASKED(input logic [15:0] data);
        RST_MASKED = '0;
        RST_MASKED[pet_pkg::BIT_SENSOR_ENABLE] = data[pet_pkg::BIT_SENSOR_ENABLE];
        RST_MASKED[pet_pkg::BIT_OUTPUT_DISABLE] = data[pet_pkg::BIT_OUTPUT_DISABLE];
    endfunction : RST_MASKED

    // =========================================================
    // read data, valid in the cycle after the strobe only
    always_comb
    begin
        next_rdata = '0;
        if (i_enable && i_read)
        begin
            if (hit(i_addr, pet_pkg::REG_POWER_CONTROL_TWO))
            begin
                next_rdata = power_control_two;
            end
            else if (hit(i_addr, pet_pkg::REG_CHARGE_PUMP_CONTROL))
            begin
                next_rdata[pet_pkg::BIT_CHARGE_PUMP] = enables.charge_pump_enable;
            end
            else if (hit(i_addr, pet_pkg::REG_OFFSET_SERVO_CONTROL))
            begin
                next_rdata[pet_pkg::BIT_RIGHT_SERVO] = enables.right_servo_enable;
                next_rdata[pet_pkg::BIT_LEFT_SERVO] = enables.left_servo_enable;
            end
            else if (hit(i_addr, pet_pkg::REG_FIRST_INTERFACE_CLOCKING))
            begin
                next_rdata[pet_pkg::BIT_INTERFACE_CLOCK] = enables.first_interface_clock_enable;
            end
            else if (hit(i_addr, pet_pkg::REG_SECOND_INTERFACE_CLOCKING))
            begin
                next_rdata[pet_pkg::BIT_INTERFACE_CLOCK] = enables.second_interface_clock_enable;
            end
            else if (hit(i_addr, pet_pkg::REG_CLOCK_GATING_CONTROL))
            begin
                next_rdata[pet_pkg::BIT_SLOW_CLOCK] = enables.slow_timeout_clock_enable;
                next_rdata[pet_pkg::BIT_FIRST_PROC] =
                    enables.first_interface_processing_clock_enable;
                next_rdata[pet_pkg::BIT_SECOND_PROC] =
                    enables.second_interface_processing_clock_enable;
                next_rdata[pet_pkg::BIT_MIXER] = enables.mixing_processor_clock_enable;
            end
            else if (hit(i_addr, pet_pkg::REG_FIRST_LOOP_CONTROL))
            begin
                next_rdata[pet_pkg::BIT_LOOP_ENABLE] = enables.first_loop_enable;
            end
            else if (hit(i_addr, pet_pkg::REG_SECOND_LOOP_CONTROL))
            begin
                next_rdata[pet_pkg::BIT_LOOP_ENABLE] = enables.second_loop_enable;
            end
            else if (hit(i_addr, pet_pkg::REG_IRQ_STATUS))
            begin
                next_rdata[1:0] = irq_status;
            end
            else if (hit(i_addr, pet_pkg::REG_IRQ_MASK))
            begin
                next_rdata[1:0] = irq_mask;
            end
            else if (hit(i_addr, pet_pkg::REG_THERMAL_STATUS))
            begin
                next_rdata[1:0] = {shutdown_level, warning_level};
            end
        end
    end

    // =========================================================
    // registers and flopped outputs
    always_ff @(posedge i_clock)
    begin
        if (!i_rstn)
        begin
            power_control_two <= pet_pkg::RST_POWER_CONTROL_TWO;
            enables <= '0;
            irq_status <= '0;
            irq_mask <= pet_pkg::RST_IRQ_MASK;
            warning_seen <= 1'b0;
            shutdown_seen <= 1'b0;
            o_rdata <= '0;
            o_enables <= '0;
            o_zero_cross_timeout_active <= 1'b0;
            o_speaker_left_out_enable <= 1'b1;
            o_speaker_right_out_enable <= 1'b1;
            o_warning_pin <= 1'b0;
            o_shutdown_pin <= 1'b0;
            o_irq <= 1'b0;
        end
        else if (i_enable)
        begin
            power_control_two <= next_power_control_two;
            enables <= next_enables;
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
            warning_seen <= next_warning_seen;
            shutdown_seen <= next_shutdown_seen;
            o_rdata <= next_rdata;
            o_enables <= next_enables;
            // zero-cross timeout needs the slow clock
            o_zero_cross_timeout_active <= i_zero_cross_request
                & next_enables.slow_timeout_clock_enable;
            // shutdown level falls only FILTER_COUNT cycles after the sensor is switched off, so the sensor bit gates it here too
            o_speaker_left_out_enable <= ~(shutdown_level
                & next_power_control_two[pet_pkg::BIT_OUTPUT_DISABLE]
                & next_power_control_two[pet_pkg::BIT_SENSOR_ENABLE]);
            o_speaker_right_out_enable <= ~(shutdown_level
                & next_power_control_two[pet_pkg::BIT_OUTPUT_DISABLE]
                & next_power_control_two[pet_pkg::BIT_SENSOR_ENABLE]);
            o_warning_pin <= warning_level;
            o_shutdown_pin <= shutdown_level;
            o_irq <= |(next_irq_status & next_irq_mask);
        end
        else
        begin
            o_rdata <= '0;
        end
    end

endmodule : pet_power_enable_thermal_guard

`default_nettype wire

// [sim/pet_power_enable_thermal_guard_monitor.sv]
`timescale 1ns/100ps
`default_nettype none

// =========================================================
// port checker
module pet_power_enable_thermal_guard_monitor #(
    parameter int FILTER_COUNT = pet_pkg::FILTER_CYCLES
) (
    // clock, reset, enable
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic i_enable,
    // register port
    input wire logic [9:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_write,
    input wire logic i_read,
    input wire logic [15:0] o_rdata,
    // thermal and volume inputs
    input wire logic i_temp_warning,
    input wire logic i_temp_shutdown,
    input wire logic i_zero_cross_request,
    // outputs
    input wire pet_pkg::pet_enables_s o_enables,
    input wire logic o_zero_cross_timeout_active,
    input wire logic o_speaker_left_out_enable,
    input wire logic o_speaker_right_out_enable,
    input wire logic o_warning_pin,
    input wire logic o_shutdown_pin,
    input wire logic o_irq
);
    // =========================================================
    // mirrors of the sensor bit and the mask
    logic sensor_on;
    logic next_sensor_on;
    logic [1:0] irq_mask;
    logic [1:0] next_irq_mask;
    logic wr_ok;

    assign wr_ok = i_enable && i_write;

    always_comb
    begin
        next_sensor_on = sensor_on;
        next_irq_mask = irq_mask;
        if (wr_ok && i_addr == pet_pkg::REG_POWER_CONTROL_TWO)
            next_sensor_on = i_wdata[14];
        if (wr_ok && i_addr == pet_pkg::REG_IRQ_MASK)
            next_irq_mask = i_wdata[1:0];
    end

    always_ff @(posedge i_clock)
    begin
        if (!i_rstn)
        begin
            sensor_on <= 1'b1;
            irq_mask <= 2'h3;
        end
        else
        begin
            sensor_on <= next_sensor_on;
            irq_mask <= next_irq_mask;
        end
    end

    // =========================================================
    // assertions
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rstn);

    chk_servo_write: assert property (
        wr_ok && i_addr == pet_pkg::REG_OFFSET_SERVO_CONTROL |=>
        {o_enables.right_servo_enable, o_enables.left_servo_enable} == $past(i_wdata[1:0]))
        else $error("servo enables do not follow the write");
    chk_slow_gate: assert property (
        !o_enables.slow_timeout_clock_enable |-> !o_zero_cross_timeout_active)
        else $error("zero-cross timeout active without slow clock");
    chk_clock_write: assert property (
        wr_ok && i_addr == pet_pkg::REG_CLOCK_GATING_CONTROL |=>
        {o_enables.slow_timeout_clock_enable, o_enables.first_interface_processing_clock_enable,
        o_enables.second_interface_processing_clock_enable,
        o_enables.mixing_processor_clock_enable} == $past(i_wdata[4:1]))
        else $error("clock gates do not follow the write");
    chk_pump_write: assert property (
        wr_ok && i_addr == pet_pkg::REG_CHARGE_PUMP_CONTROL |=>
        o_enables.charge_pump_enable == $past(i_wdata[15]))
        else $error("charge pump enable does not follow the write");
    chk_iface_write: assert property (
        wr_ok && i_addr == pet_pkg::REG_FIRST_INTERFACE_CLOCKING |=>
        o_enables.first_interface_clock_enable == $past(i_wdata[0]))
        else $error("interface clock enable does not follow the write");
    chk_speaker_cool: assert property (
        !o_shutdown_pin |-> o_speaker_left_out_enable && o_speaker_right_out_enable)
        else $error("speaker disabled without shutdown level");
    chk_shutdown_cause: assert property (
        $rose(o_shutdown_pin) |-> $past(i_temp_shutdown, 3))
        else $error("shutdown pin rose without shutdown input");
    chk_sensor_rise: assert property (
        ($rose(o_warning_pin) || $rose(o_shutdown_pin)) |-> sensor_on)
        else $error("thermal pin rose with sensor off");
    chk_warning_irq: assert property (
        $rose(o_warning_pin) && irq_mask[0] |-> ##[0:2] o_irq)
        else $error("unmasked warning raised no interrupt");

    cover property ($rose(o_irq));
    cover property ($fell(o_speaker_left_out_enable));
    cover property (wr_ok && i_addr == pet_pkg::REG_CLOCK_GATING_CONTROL);
endmodule : pet_power_enable_thermal_guard_monitor

bind pet_power_enable_thermal_guard pet_power_enable_thermal_guard_monitor #(
    .FILTER_COUNT(FILTER_COUNT)
) pet_power_enable_thermal_guard_monitor_i (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_enable(i_enable), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_write(i_write), .i_read(i_read), .o_rdata(o_rdata),
    .i_temp_warning(i_temp_warning), .i_temp_shutdown(i_temp_shutdown),
    .i_zero_cross_request(i_zero_cross_request), .o_enables(o_enables),
    .o_zero_cross_timeout_active(o_zero_cross_timeout_active),
    .o_speaker_left_out_enable(o_speaker_left_out_enable),
    .o_speaker_right_out_enable(o_speaker_right_out_enable),
    .o_warning_pin(o_warning_pin), .o_shutdown_pin(o_shutdown_pin), .o_irq(o_irq)
);

`default_nettype wire

// [sim/pet_power_enable_thermal_guard_bench.sv]
`timescale 1ns/100ps
`default_nettype none

module pet_power_enable_thermal_guard_bench;
    // short filter keeps the thermal waits brief
    localparam int FC = 2;
    logic i_clock = 1'b0;
    logic i_rstn = 1'b0;
    logic i_enable = 1'b1;
    logic [9:0] i_addr = 10'h000;
    logic [15:0] i_wdata = 16'h0000;
    logic i_write = 1'b0;
    logic i_read = 1'b0;
    logic i_temp_warning = 1'b0;
    logic i_temp_shutdown = 1'b0;
    logic i_zero_cross_request = 1'b0;
    logic [15:0] o_rdata;
    pet_pkg::pet_enables_s o_enables;
    logic o_zc, o_spk_l, o_spk_r, o_warn, o_shut, o_irq;
    int error_cnt = 0;
    int checked = 0;
    int seed = 32'h6b2dcc25;
    logic rd_pend = 1'b0;
    logic [15:0] q [$];
    logic [9:0] ra [9] = '{10'h002, 10'h04c, 10'h054, 10'h200, 10'h204, 10'h208,
        10'h220, 10'h240, 10'h301};
    logic [15:0] rm [9] = '{16'h6000, 16'h8000, 16'h0003, 16'h0001, 16'h0001, 16'h001e,
        16'h0001, 16'h0001, 16'h0003};
    logic [15:0] mv [9] = '{16'h6000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
        16'h0000, 16'h0000, 16'h0003};

    pet_power_enable_thermal_guard #(
        .FILTER_COUNT(FC)
    ) pet_power_enable_thermal_guard_i (
        .i_clock(i_clock), .i_rstn(i_rstn), .i_enable(i_enable), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_write(i_write), .i_read(i_read), .o_rdata(o_rdata),
        .i_temp_warning(i_temp_warning), .i_temp_shutdown(i_temp_shutdown),
        .i_zero_cross_request(i_zero_cross_request), .o_enables(o_enables),
        .o_zero_cross_timeout_active(o_zc), .o_speaker_left_out_enable(o_spk_l),
        .o_speaker_right_out_enable(o_spk_r), .o_warning_pin(o_warn),
        .o_shutdown_pin(o_shut), .o_irq(o_irq)
    );

    always #50 i_clock = ~i_clock;

    task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e)
        begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : check

    // =========================================================
    // bus cycles; strobes drop only in idle, so calls may follow back to back
    task automatic wr(input logic [9:0] a, input logic [15:0] d);
        @(posedge i_clock);
        {i_write, i_read, i_addr, i_wdata} <= {2'b10, a, d};
    endtask : wr

    task automatic rd(input logic [9:0] a, input logic [15:0] e);
        @(posedge i_clock);
        {i_write, i_read, i_addr} <= {2'b01, a};
        q.push_back(e);
    endtask : rd

    task automatic idle();
        @(posedge i_clock);
        {i_write, i_read} <= 2'b00;
    endtask : idle

    // =========================================================
    // answer watcher
    always @(posedge i_clock) rd_pend <= i_read && i_enable && i_rstn;
    always @(negedge i_clock)
        if (rd_pend && q.size() > 0)
            check("read data", q.pop_front(), o_rdata);
        else
            check("idle rdata", 16'h0000, o_rdata);

    // temperature step, then look after the filter has settled
    task automatic heat(input logic w, input logic s);
        @(posedge i_clock);
        {i_temp_warning, i_temp_shutdown} <= {w, s};
        repeat (FC + 8) @(posedge i_clock);
    endtask : heat

    task automatic ports(input logic [4:0] e);
        @(negedge i_clock);
        check("thermal ports", {11'h0, e}, {11'h0, o_spk_l, o_spk_r, o_warn, o_shut, o_irq});
    endtask : ports

    task close_out();
        if (error_cnt == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : close_out

    initial
    begin
        repeat (6000) @(posedge i_clock);
        error_cnt++;
        close_out();
    end

    initial
    begin
        repeat (10) @(posedge i_clock);
        i_rstn <= 1'b1;
        for (int i = 0; i < 9; i++)
            rd(ra[i], mv[i]);
        rd(10'h300, 16'h0000);
        rd(10'h3ff, 16'h0000);
        idle();
        ports(5'b11000);
        for (int r = 0; r < 3; r++)
            for (int i = 0; i < 9; i++)
            begin
                mv[i] = $random(seed) & rm[i];
                wr(ra[i], $random(seed) & ~rm[i] | mv[i]);
                rd(ra[i], mv[i]);
            end
        wr(10'h3ff, 16'hffff);
        rd(10'h3ff, 16'h0000);
        idle();
        @(negedge i_clock);
        check("enables", {5'h0, mv[1][15], mv[2][1:0], mv[3][0], mv[4][0], mv[5][4:1],
            mv[6][0], mv[7][0]}, {5'h0, o_enables});
        // frozen block must ignore a write
        @(posedge i_clock) i_enable <= 1'b0;
        wr(10'h04c, ~mv[1]);
        idle();
        @(posedge i_clock) i_enable <= 1'b1;
        rd(10'h04c, mv[1]);
        wr(10'h208, 16'h0010);
        idle();
        i_zero_cross_request <= 1'b1;
        repeat (3) @(posedge i_clock);
        @(negedge i_clock) check("zero cross", 16'h0001, {15'h0, o_zc});
        wr(10'h208, 16'h000e);
        idle();
        repeat (3) @(posedge i_clock);
        @(negedge i_clock) check("zero cross", 16'h0000, {15'h0, o_zc});
        wr(10'h002, 16'h6000);
        wr(10'h301, 16'h0003);
        wr(10'h300, 16'h0003);
        idle();
        heat(1'b1, 1'b0);
        ports(5'b11101);
        rd(10'h300, 16'h0001);
        rd(10'h302, 16'h0001);
        idle();
        heat(1'b1, 1'b1);
        ports(5'b00111);
        rd(10'h300, 16'h0003);
        wr(10'h300, 16'h0003);
        rd(10'h300, 16'h0000);
        idle();
        repeat (3) @(posedge i_clock);
        ports(5'b00110);
        heat(1'b0, 1'b0);
        ports(5'b11000);
        wr(10'h002, 16'h4000);
        idle();
        heat(1'b0, 1'b1);
        ports(5'b11011);
        wr(10'h300, 16'h0003);
        idle();
        heat(1'b0, 1'b0);
        wr(10'h002, 16'h2000);
        idle();
        heat(1'b1, 1'b1);
        ports(5'b11000);
        rd(10'h300, 16'h0000);
        idle();
        heat(1'b0, 1'b0);
        wr(10'h002, 16'h6000);
        wr(10'h301, 16'h0000);
        idle();
        heat(1'b1, 1'b0);
        ports(5'b11100);
        rd(10'h300, 16'h0001);
        wr(10'h301, 16'h0001);
        idle();
        repeat (3) @(posedge i_clock);
        ports(5'b11101);
        wr(10'h300, 16'h0001);
        idle();
        repeat (3) @(posedge i_clock);
        ports(5'b11100);
        heat(1'b0, 1'b0);
        close_out();
    end
endmodule : pet_power_enable_thermal_guard_bench

`default_nettype wire
